// *** design/eac_access_ctrl.sv ***
/*
  EEPROM access controller: APB register slave, programming sequencer,
  read path, processor stall and interrupt logic.
  Assumes the processor reaches it over APB on core_clk and honours cpuHalt.
*/
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module eac_access_ctrl
  import eac_pkg::*;
#(
  parameter int ATOMIC_TICKS = ATOMIC_TICKS_DEF,
  parameter int SPLIT_TICKS  = SPLIT_TICKS_DEF,
  parameter int TICK_DIV     = TICK_DIV_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic        globalIntEnable,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             readyIrq,
  output logic             cpuHalt
);

  // Register state
  logic [ADDR_W-1:0]  nvAddr;
  logic [DATA_W-1:0]  nvData;
  eac_mode_t          mode;
  logic               rie;
  logic               mpe;
  logic [STALL_W-1:0] mpeCnt;
  logic               pe;
  eac_state_t         state;
  logic [TIMER_W-1:0] progTimer;
  eac_nvcmd_t         cmd;
  logic [STALL_W-1:0] stallCnt;
  logic [IRQ_W-1:0]   irqStatus;
  logic [IRQ_W-1:0]   irqMask;
  logic               tick;
  logic [DATA_W-1:0]  arrayRdata;

  // Index match shared by every register select
  function automatic logic idx_hit(input logic [7:0] i, input logic [7:0] target);
    return (i == target);
  endfunction

  // Bus decode
  wire [7:0] idx     = paddr[9:IDX_LSB];
  wire       hitCtrl = idx_hit(idx, IDX_CTRL);
  wire       hitData = idx_hit(idx, IDX_DATA);
  wire       hitAdrL = idx_hit(idx, IDX_ADDRL);
  wire       hitAdrH = idx_hit(idx, IDX_ADDRH);
  wire       hitStat = idx_hit(idx, IDX_IRQ_STAT);
  wire       hitMask = idx_hit(idx, IDX_IRQ_MASK);
  wire       mapped  = hitCtrl | hitData | hitAdrL | hitAdrH | hitStat | hitMask;

  // A transfer completes on the edge where pready is sampled high
  wire       access  = psel & penable & pready;
  wire       wrEn    = access & pwrite & pstrb[0] & mapped;
  wire [7:0] wbyte   = pwdata[7:0];
  wire       ctrlWr  = wrEn & hitCtrl;

  wire eac_mode_t wrMode = eac_mode_t'(wbyte[CTRL_MODE +: 2]);
  // Mode written in the same access that sets program enable applies to it
  wire eac_mode_t useMode = pe ? mode : wrMode;

  // Operation requests
  wire idle    = (state == EAC_IDLE);
  wire reqRead = ctrlWr & wbyte[CTRL_RE] & idle;
  wire reqProg = ctrlWr & wbyte[CTRL_PE] & mpe & idle & (useMode != EAC_MODE_RSVD);
  wire commit  = (state == EAC_PROG) & (progTimer == '0);

  wire [TIMER_W-1:0] atomicLoad = TIMER_W'(ATOMIC_TICKS);
  wire [TIMER_W-1:0] splitLoad  = TIMER_W'(SPLIT_TICKS);
  wire [TIMER_W-1:0] progLoad   = (useMode == EAC_MODE_ATOMIC) ? atomicLoad : splitLoad;

  // Sequencer next values, named so each flop block stays short
  wire             startProg = idle & reqProg;
  wire             timerStep = (state == EAC_PROG) & ~commit & tick;
  wire eac_nvcmd_t next_cmd  = '{erase: (useMode != EAC_MODE_WRITE),
                                 write: (useMode != EAC_MODE_ERASE),
                                 addr:  nvAddr,
                                 data:  nvData};

  // Stall counter
  wire [STALL_W-1:0] next_stall =
    reqRead ? READ_STALL :
    reqProg ? PROG_STALL :
    (stallCnt != '0) ? stallCnt - 3'h1 : stallCnt;

  // Interrupt status, set wins over a clear in the same cycle
  wire [IRQ_W-1:0] irqEvent  = {reqRead, commit};
  wire [IRQ_W-1:0] irqClear  = (wrEn & hitStat) ? wbyte[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_stat = (irqStatus & ~irqClear) | irqEvent;

  // Read-back mux; reserved bits read as zero
  wire [7:0] ctrlRd = {2'b00, mode, rie, mpe, pe, 1'b0};
  wire [7:0] rdByte =
    hitCtrl ? ctrlRd :
    hitData ? nvData :
    hitAdrL ? nvAddr[7:0] :
    hitAdrH ? {7'h00, nvAddr[8]} :
    hitStat ? {6'h00, irqStatus} :
    hitMask ? {6'h00, irqMask} : 8'h00;

  eac_tick_div #(
    .DIV      (TICK_DIV)
  ) u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick)
  );

  eac_nv_array u_array (
    .core_clk (core_clk),
    .commit   (commit),
    .cmd      (cmd),
    .raddr    (nvAddr),
    .rdata    (arrayRdata)
  );

  // APB answer: pready rises once the stall has run out
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready & (stallCnt == '0);
      prdata  <= {24'h00_0000, rdByte};
      // Error must travel with pready, so it waits out a stall as well
      pslverr <= psel & penable & ~pready & (stallCnt == '0) & ~mapped;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stallCnt <= '0;
      cpuHalt  <= 1'b0;
    end else begin
      stallCnt <= next_stall;
      cpuHalt  <= (next_stall != '0);
    end
  end

  // Address register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvAddr <= '0;
    end else begin
      if (wrEn & hitAdrL)
        nvAddr[7:0] <= wbyte;
      if (wrEn & hitAdrH)
        nvAddr[8] <= wbyte[0];
    end
  end

  // Data register; a read lands here during the stall
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvData <= '0;
    end else if (reqRead) begin
      nvData <= arrayRdata;
    end else if (wrEn & hitData) begin
      nvData <= wbyte;
    end
  end

  // Mode field and ready interrupt enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= EAC_MODE_ATOMIC;
      rie  <= 1'b0;
    end else if (ctrlWr) begin
      rie <= wbyte[CTRL_RIE];
      if (!pe)
        mode <= wrMode;
    end
  end

  // Master enable opens a short window, then closes itself
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mpe    <= 1'b0;
      mpeCnt <= '0;
    end else if (reqProg) begin
      mpe    <= 1'b0;
      mpeCnt <= '0;
    end else if (ctrlWr & wbyte[CTRL_MPE]) begin
      mpe    <= 1'b1;
      mpeCnt <= MPE_WINDOW;
    end else if (ctrlWr) begin
      mpe    <= 1'b0;
      mpeCnt <= '0;
    end else if (mpeCnt != '0) begin
      mpeCnt <= mpeCnt - 3'h1;
      mpe    <= (mpeCnt != 3'h1);
    end
  end

  // Programming sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= EAC_IDLE;
      pe    <= 1'b0;
    end else begin
      unique case (state)
        EAC_IDLE: begin
          if (startProg) begin
            state <= EAC_PROG;
            pe    <= 1'b1;
          end
        end
        EAC_PROG: begin
          if (commit) begin
            state <= EAC_IDLE;
            pe    <= 1'b0;
          end
        end
      endcase
    end
  end

  // Self timer counts oscillator ticks, never core clocks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      progTimer <= '0;
    end else if (startProg) begin
      progTimer <= progLoad;
    end else if (timerStep) begin
      progTimer <= progTimer - 12'h001;
    end
  end

  // Command captured at start; later register writes cannot disturb it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else if (startProg) begin
      cmd <= next_cmd;
    end
  end

  // Interrupts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus <= '0;
      irqMask   <= '0;
      irq       <= 1'b0;
      readyIrq  <= 1'b0;
    end else begin
      irqStatus <= next_stat;
      if (wrEn & hitMask)
        irqMask <= wbyte[IRQ_W-1:0];
      irq      <= |(next_stat & irqMask);
      // Level source: follows readiness, never latched
      readyIrq <= rie & globalIntEnable & ~pe & ~reqProg;
    end
  end

endmodule
`default_nettype wire

// *** design/eac_pkg.sv ***
/*
  Shared constants, types and timing figures of the EEPROM access controller.
  Assumes a 100 MHz core clock and a calibrated oscillator giving a 1 MHz tick.
*/
package eac_pkg;

  // Largest variant; smaller parts leave the top address bits unused
  localparam int NV_BYTES = 512;
  localparam int ADDR_W   = 9;
  localparam int DATA_W   = 8;

  // Register indices; byte address is four times the index
  localparam int          IDX_LSB      = 2;
  localparam logic [7:0]  IDX_CTRL     = 8'h1C;
  localparam logic [7:0]  IDX_DATA     = 8'h1D;
  localparam logic [7:0]  IDX_ADDRL    = 8'h1E;
  localparam logic [7:0]  IDX_ADDRH    = 8'h1F;
  localparam logic [7:0]  IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0]  IDX_IRQ_MASK = 8'h21;

  // Control register bit positions
  localparam int CTRL_RE   = 0;
  localparam int CTRL_PE   = 1;
  localparam int CTRL_MPE  = 2;
  localparam int CTRL_RIE  = 3;
  localparam int CTRL_MODE = 4;

  // Interrupt status bits
  localparam int IRQ_W         = 2;
  localparam int IRQ_PROG_DONE = 0;
  localparam int IRQ_READ_DONE = 1;

  typedef enum logic [1:0] {
    EAC_MODE_ATOMIC = 2'b00,
    EAC_MODE_ERASE  = 2'b01,
    EAC_MODE_WRITE  = 2'b10,
    EAC_MODE_RSVD   = 2'b11
  } eac_mode_t;

  typedef enum logic [0:0] {
    EAC_IDLE = 1'b0,
    EAC_PROG = 1'b1
  } eac_state_t;

  typedef struct packed {
    logic               erase;
    logic               write;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  data;
  } eac_nvcmd_t;

  // Clock and oscillator tick rates
  localparam int CLK_HZ       = 100_000_000;
  localparam int OSC_HZ       = 1_000_000;
  localparam int TICK_DIV_DEF = CLK_HZ / OSC_HZ;

  // Self-timed programming durations, rounded up to whole ticks
  localparam real ATOMIC_TIME_MS   = 3.4;
  localparam real SPLIT_TIME_MS    = 1.8;
  localparam int  ATOMIC_TICKS_DEF = int'($ceil(ATOMIC_TIME_MS * OSC_HZ / 1000.0));
  localparam int  SPLIT_TICKS_DEF  = int'($ceil(SPLIT_TIME_MS * OSC_HZ / 1000.0));
  localparam int  TIMER_W          = 12;

  // Core clock cycle counts
  localparam int         STALL_W    = 3;
  localparam logic [2:0] MPE_WINDOW = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] PROG_STALL = 3'h2;

endpackage

// *** design/eac_tick_div.sv ***
/*
  Divider that stands in for the calibrated oscillator: one-cycle tick enable.
  Assumes a single core clock; DIV is at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module eac_tick_div #(
  parameter int DIV = 100
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      tick
);
  logic [15:0] cnt;
  wire         wrap = (cnt == 16'(DIV - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt  <= wrap ? 16'h0000 : cnt + 16'h0001;
      tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// *** design/eac_nv_array.sv ***
/*
  Byte storage of the nonvolatile data space, held in flip-flops.
  Assumes the controller issues one commit per finished programming operation.
*/
`timescale 1ns/1ps
`default_nettype none
module eac_nv_array
  import eac_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              commit,
  input  wire eac_nvcmd_t        cmd,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [NV_BYTES];
  logic [DATA_W-1:0] next_byte;

  // Write without erase can only clear bits, as in a real cell
  always_comb begin
    next_byte = mem[cmd.addr];
    if (cmd.erase)
      next_byte = 8'hFF;
    if (cmd.write)
      next_byte = next_byte & cmd.data;
  end

  always_ff @(posedge core_clk) begin
    if (commit)
      mem[cmd.addr] <= next_byte;
  end

  assign rdata = mem[raddr];
endmodule
`default_nettype wire

// *** dv/eac_access_ctrl_checker.sv ***
/* Port assertions for the access controller.
   Assumes one core clock and the active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module eac_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        globalIntEnable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        readyIrq,
  input wire logic        cpuHalt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_in_access: assert property (pready |-> $past(psel && penable))
    else $error("pready outside access");
  a_data_byte: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  a_halt_min: assert property ($rose(cpuHalt) |-> cpuHalt[*2])
    else $error("halt too short");
  a_halt_max: assert property (cpuHalt[*4] |=> !cpuHalt)
    else $error("halt too long");
  a_ready_bound: assert property ($rose(penable) && psel |-> ##[1:6] pready)
    else $error("no answer");
  a_ready_irq_gate: assert property (!globalIntEnable |=> !readyIrq)
    else $error("ready interrupt ungated");
endmodule
bind eac_access_ctrl eac_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .globalIntEnable(globalIntEnable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .readyIrq(readyIrq), .cpuHalt(cpuHalt));
`default_nettype wire

// *** dv/eac_cpu_model.sv ***
/* Processor side: APB master and the access sequences.
   Tasks are entered just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module eac_cpu_model
  import eac_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  logic [31:0] rdat;
  logic        rerr;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {3'h0, 44'h0, 4'hF};
  // Chain keeps psel up so the next setup follows at once
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, input logic chain);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdat = prdata;
    rerr = pslverr;
    if (!chain) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    xfer(1'b1, idx, wd, 1'b0);
  endtask
  task automatic rd(input logic [7:0] idx);
    xfer(1'b0, idx, 8'h00, 1'b0);
  endtask
  task automatic idle_wait;
    rd(IDX_CTRL);
    while (rdat[CTRL_PE]) rd(IDX_CTRL);
  endtask
  task automatic set_addr(input logic [8:0] a);
    wr(IDX_ADDRH, {7'h0, a[8]});
    wr(IDX_ADDRL, a[7:0]);
  endtask
  task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
    idle_wait();
    wr(IDX_CTRL, {2'h0, m, 4'h0});
    set_addr(a);
    wr(IDX_DATA, d);
    xfer(1'b1, IDX_CTRL, {2'h0, m, 4'h4}, 1'b1);
    xfer(1'b1, IDX_CTRL, {2'h0, m, 4'h6}, 1'b0);
  endtask
  task automatic readb(input logic [8:0] a);
    idle_wait();
    set_addr(a);
    wr(IDX_CTRL, 8'h01);
    rd(IDX_DATA);
  endtask
endmodule
`default_nettype wire

// *** dv/eeprom_access_controller_tb.sv ***
/* Self-checking bench for the access controller.
   Shortened timing parameters; processor model drives APB. */
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_controller_tb
  import eac_pkg::*;
;
  localparam int AT = 30;
  localparam int SP = 15;
  logic        core_clk;
  logic        rst_n;
  logic        gie;
  wire logic   psel, penable, pwrite, pready, pslverr, irq, readyIrq, cpuHalt;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic [3:0]  pstrb;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          t0;
  int          n;
  logic [31:0] seed;
  logic [8:0]  a;
  logic [7:0]  old, dat;
  logic [1:0]  m;
  eac_access_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(SP), .TICK_DIV(2)) u_dut (.core_clk(core_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .globalIntEnable(gie), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .readyIrq(readyIrq), .cpuHalt(cpuHalt));
  eac_cpu_model u_cpu (.core_clk(core_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'hA300_0001 : 32'h0);
  endfunction
  function automatic logic [7:0] exp_byte(input logic [1:0] md, input logic [7:0] o, input logic [7:0] d);
    case (md)
      EAC_MODE_ATOMIC: return d;
      EAC_MODE_ERASE:  return 8'hFF;
      EAC_MODE_WRITE:  return o & d;
      default:         return o;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    gie = 1'b0;
    seed = 32'hEF13;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    u_cpu.rd(IDX_CTRL);
    chk(u_cpu.rdat, 32'h0);
    u_cpu.rd(8'h30);
    chk({31'h0, u_cpu.rerr}, 32'h1);
    u_cpu.wr(IDX_CTRL, 8'h04);
    repeat (4) @(posedge core_clk);
    u_cpu.wr(IDX_CTRL, 8'h02);
    u_cpu.rd(IDX_CTRL);
    chk(u_cpu.rdat, 32'h0);
    u_cpu.wr(IDX_IRQ_MASK, 8'h01);
    u_cpu.wr(IDX_CTRL, 8'h08);
    gie <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({31'h0, readyIrq}, 32'h1);
    gie <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({31'h0, readyIrq}, 32'h0);
    gie <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = seed[8:0];
      old = seed[15:8];
      dat = seed[23:16];
      m = i[1:0];
      u_cpu.prog(a, old, (m == 2'b10) ? 2'b01 : 2'b00);
      if (m == 2'b10) old = 8'hFF;
      u_cpu.prog(a, dat, m);
      t0 = cyc;
      u_cpu.wr(IDX_IRQ_STAT, 8'h03);
      if (m != 2'b11) u_cpu.wr(IDX_CTRL, {2'h0, 2'h3 ^ m, 4'h1});
      u_cpu.rd(IDX_CTRL);
      chk(u_cpu.rdat, {26'h0, m, 2'b00, m != 2'b11, 1'b0});
      u_cpu.rd(IDX_DATA);
      chk(u_cpu.rdat, {24'h0, dat});
      u_cpu.idle_wait();
      n = (m == 2'b00) ? AT : SP;
      if (m != 2'b11) chk({31'h0, (cyc - t0) >= 2 * n - 2 && (cyc - t0) <= 2 * n + 8}, 32'h1);
      chk({31'h0, irq}, {31'h0, m != 2'b11});
      u_cpu.wr(IDX_IRQ_STAT, 8'h01);
      chk({31'h0, irq}, 32'h0);
      u_cpu.readb(a);
      chk(u_cpu.rdat, {24'h0, exp_byte(m, old, dat)});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
